// file: rtl/rcc_pkg.sv
package rcc_pkg;

   localparam logic [7:0] RCC_ADDR_CONTROL  = 8'h17;
   localparam logic [7:0] RCC_ADDR_RATIO    = 8'h18;
   localparam logic [7:0] RCC_RESET_VALUE   = 8'h00;
   localparam logic [7:0] RCC_CONTROL_WMASK = 8'hC0;
   localparam logic [7:0] RCC_RATIO_WMASK   = 8'hFF;
   localparam int         RCC_BIT_ENABLE    = 7;
   localparam int         RCC_BIT_AUTODIS   = 6;
   localparam int         RCC_BIT_MANUAL    = 7;
   localparam int         RCC_BIT_SOURCE    = 6;
   localparam int         RCC_NUM_LSB       = 3;
   localparam int         RCC_DEN_LSB       = 0;
   localparam logic [2:0] RCC_RATIO_AUTO    = 3'h0;
   localparam logic [2:0] RCC_RATIO_RSV5    = 3'h5;
   localparam logic [2:0] RCC_RATIO_RSV7    = 3'h7;

   typedef enum logic [0:0] {
      RCC_SRC_PRIMARY   = 1'b0,
      RCC_SRC_SECONDARY = 1'b1
   } rcc_source_t;

   typedef struct packed {
      logic [7:0] control;
      logic [7:0] ratio;
      logic [7:0] rdata;
   } rcc_state_t;

   typedef struct packed {
      logic        converter_enable;
      logic        rate_autodetect_disable;
      logic        main_rate_manual;
      rcc_source_t main_rate_source;
      logic        numerator_auto;
      logic [2:0]  numerator;
      logic        denominator_auto;
      logic [2:0]  denominator;
      logic        ratio_reserved;
   } rcc_config_t;

endpackage : rcc_pkg

// file: rtl/rcc_ratio_decode.sv
`timescale 1ns/1ps
module rcc_ratio_decode (
   input  wire logic [2:0] code_in,
   output logic            auto_out,
   output logic [2:0]      value_out,
   output logic            reserved_out
);
   always_comb begin
      auto_out     = (code_in == rcc_pkg::RCC_RATIO_AUTO);
      reserved_out = (code_in == rcc_pkg::RCC_RATIO_RSV5) || (code_in == rcc_pkg::RCC_RATIO_RSV7);
      // Codes 1..4 and 6 are the literal ratio term itself
      value_out    = (auto_out || reserved_out) ? 3'h0 : code_in;
   end
endmodule : rcc_ratio_decode

// file: rtl/rcc_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Control bit 7 switches the rate converter on when set, off when clear.
// - Control bit 6 set disables automatic rate detection; clear keeps it active.
// - Control bits 5..0 are reserved, read zero; software writes only zero.
// - Both registers at 0x17 and 0x18 reset to all zeros.
// - Manual bit clear infers main rate; set uses the source selection bit.
// - Source bit clear picks primary port rate, set picks secondary port rate.
// - Numerator field: 0 automatic, 1..4 literal, 6 is six; 5 and 7 reserved.
// - Denominator field: 0 automatic, 1..4 literal, 6 is six; 5 and 7 reserved.
// - Source choice names the primary and secondary audio serial interfaces.
module rcc_regs (
   input  wire logic               core_clk_in,
   input  wire logic               rst_in,
   input  wire logic               clk_en_in,
   input  wire logic               wr_en_in,
   input  wire logic               rd_en_in,
   input  wire logic [7:0]         addr_in,
   input  wire logic [7:0]         wdata_in,
   output logic [7:0]              rdata_out,
   output logic                    addr_hit_out,
   output logic                    converter_enable_out,
   output logic                    rate_autodetect_disable_out,
   output logic                    main_rate_manual_out,
   output logic                    main_rate_from_secondary_out,
   output rcc_pkg::rcc_config_t    config_out
);
   rcc_pkg::rcc_state_t state_reg;
   rcc_pkg::rcc_state_t state_next;
   logic                num_auto;
   logic [2:0]          num_value;
   logic                num_rsv;
   logic                den_auto;
   logic [2:0]          den_value;
   logic                den_rsv;

   function automatic logic [7:0] rcc_read(input logic [7:0] a, input rcc_pkg::rcc_state_t s);
      if (a == rcc_pkg::RCC_ADDR_CONTROL) begin
         rcc_read = s.control & rcc_pkg::RCC_CONTROL_WMASK;
      end else if (a == rcc_pkg::RCC_ADDR_RATIO) begin
         rcc_read = s.ratio;
      end else begin
         rcc_read = 8'h00;
      end
   endfunction : rcc_read

   always_comb begin
      state_next = state_reg;
      if (wr_en_in && addr_in == rcc_pkg::RCC_ADDR_CONTROL) begin
         state_next.control = wdata_in & rcc_pkg::RCC_CONTROL_WMASK;
      end
      if (wr_en_in && addr_in == rcc_pkg::RCC_ADDR_RATIO) begin
         state_next.ratio = wdata_in & rcc_pkg::RCC_RATIO_WMASK;
      end
      if (rd_en_in) begin
         state_next.rdata = rcc_read(addr_in, state_reg);
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state_reg <= {rcc_pkg::RCC_RESET_VALUE, rcc_pkg::RCC_RESET_VALUE, rcc_pkg::RCC_RESET_VALUE};
      end else if (clk_en_in) begin
         state_reg <= state_next;
      end
   end

   rcc_ratio_decode u_num (
      .code_in      (state_reg.ratio[rcc_pkg::RCC_NUM_LSB +: 3]),
      .auto_out     (num_auto),
      .value_out    (num_value),
      .reserved_out (num_rsv)
   );

   rcc_ratio_decode u_den (
      .code_in      (state_reg.ratio[rcc_pkg::RCC_DEN_LSB +: 3]),
      .auto_out     (den_auto),
      .value_out    (den_value),
      .reserved_out (den_rsv)
   );

   assign rdata_out                    = state_reg.rdata;
   assign addr_hit_out                 = (addr_in == rcc_pkg::RCC_ADDR_CONTROL) || (addr_in == rcc_pkg::RCC_ADDR_RATIO);
   assign converter_enable_out         = state_reg.control[rcc_pkg::RCC_BIT_ENABLE];
   assign rate_autodetect_disable_out  = state_reg.control[rcc_pkg::RCC_BIT_AUTODIS];
   assign main_rate_manual_out         = state_reg.ratio[rcc_pkg::RCC_BIT_MANUAL];
   // Source only matters once the manual choice is taken
   assign main_rate_from_secondary_out = state_reg.ratio[rcc_pkg::RCC_BIT_MANUAL]
                                         & state_reg.ratio[rcc_pkg::RCC_BIT_SOURCE];

   always_comb begin
      config_out.converter_enable        = state_reg.control[rcc_pkg::RCC_BIT_ENABLE];
      config_out.rate_autodetect_disable = state_reg.control[rcc_pkg::RCC_BIT_AUTODIS];
      config_out.main_rate_manual        = state_reg.ratio[rcc_pkg::RCC_BIT_MANUAL];
      config_out.main_rate_source        = rcc_pkg::rcc_source_t'(state_reg.ratio[rcc_pkg::RCC_BIT_SOURCE]);
      config_out.numerator_auto          = num_auto;
      config_out.numerator               = num_value;
      config_out.denominator_auto        = den_auto;
      config_out.denominator             = den_value;
      config_out.ratio_reserved          = num_rsv | den_rsv;
   end
endmodule : rcc_regs

// file: tb/rcc_regs_checker.sv
`timescale 1ns/1ps
module rcc_regs_checker (
   input wire logic core_clk_in, rst_in, clk_en_in, wr_en_in, rd_en_in, addr_hit_out,
   input wire logic [7:0] addr_in, wdata_in, rdata_out,
   input wire logic converter_enable_out, rate_autodetect_disable_out,
   input wire logic main_rate_manual_out, main_rate_from_secondary_out,
   input wire rcc_pkg::rcc_config_t config_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   wire w_ctl = wr_en_in && clk_en_in && addr_in == 8'h17;
   wire w_rat = wr_en_in && clk_en_in && addr_in == 8'h18;
   a_enable_follow: assert property (w_ctl |=> converter_enable_out == $past(wdata_in[7])) else $error("enable");
   a_autodis_follow: assert property (w_ctl |=> rate_autodetect_disable_out == $past(wdata_in[6])) else $error("autodis");
   a_reserved_zero: assert property (rd_en_in && clk_en_in && addr_in != 8'h18 |=>
      rdata_out[5:0] == 6'h00) else $error("reserved bits");
   a_reset_clears: assert property ($fell(rst_in) && $past(clk_en_in) |-> !converter_enable_out &&
      !main_rate_manual_out && config_out.numerator_auto && rdata_out == 8'h00) else $error("reset value");
   a_manual_follow: assert property (w_rat |=> main_rate_manual_out == $past(wdata_in[7])) else $error("manual");
   a_source_pick: assert property (w_rat |=> main_rate_from_secondary_out ==
      ($past(wdata_in[7]) && $past(wdata_in[6]))) else $error("source");
   a_num_literal: assert property (w_rat && !(wdata_in[5:3] inside {3'h5, 3'h7}) |=>
      config_out.numerator == $past(wdata_in[5:3])) else $error("numerator");
   a_den_reserved: assert property (w_rat && wdata_in[2:0] == 3'h7 |=>
      config_out.ratio_reserved && config_out.denominator == 3'h0) else $error("denominator");
   a_config_hold: assert property (!(wr_en_in && clk_en_in) |=> $stable(config_out)) else $error("config hold");
   c_ctl_write: cover property (w_ctl);
   c_secondary: cover property (w_rat && wdata_in[7:6] == 2'h3);
   c_reserved: cover property (config_out.ratio_reserved);
endmodule : rcc_regs_checker
bind rcc_regs rcc_regs_checker u_chk (.*);

// file: tb/test_rate_converter_config.sv
`timescale 1ns/1ps
module test_rate_converter_config;
   logic core_clk_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1, wr_en_in = 1'b0, rd_en_in = 1'b0;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, d, e;
   logic addr_hit_out, converter_enable_out, rate_autodetect_disable_out;
   logic main_rate_manual_out, main_rate_from_secondary_out;
   rcc_pkg::rcc_config_t config_out;
   int err_count = 0, checks = 0, cyc = 0;
   always #12.5 core_clk_in = ~core_clk_in;
   rcc_regs u_dut (.*);
   function automatic logic [7:0] lit(logic [2:0] c);
      return (c inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6}) ? {5'h00, c} : 8'h00;
   endfunction : lit
   task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [7:0] v);
      @(negedge core_clk_in) {wr_en_in, addr_in, wdata_in} = {1'b1, a, v};
      @(negedge core_clk_in) wr_en_in = 1'b0;
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] exp);
      @(negedge core_clk_in) {rd_en_in, addr_in} = {1'b1, a};
      #1 chk("hit", {7'h00, a == 8'h17 || a == 8'h18}, {7'h00, addr_hit_out});
      @(negedge core_clk_in) rd_en_in = 1'b0;
      chk("rdata", exp, rdata_out);
   endtask : rd
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   always @(posedge core_clk_in) if (++cyc == 2000) begin
      err_count++;
      report_and_stop();
   end
   initial begin
      void'($urandom(1));
      repeat (4) @(negedge core_clk_in);
      rst_in = 1'b0;
      rd(8'h17, 8'h00);
      rd(8'h18, 8'h00);
      for (int n = 0; n < 24; n++) begin
         d = {2'($urandom), 6'h00};
         e = (n < 8) ? {n[1:0], n[2:0], 3'(7 - n)} : 8'($urandom);
         wr(8'h17, d);
         wr(8'h18, e);
         chk("outs", {4'h0, d[7:6], e[7], e[7] & e[6]}, {4'h0, converter_enable_out,
            rate_autodetect_disable_out, main_rate_manual_out, main_rate_from_secondary_out});
         chk("num", lit(e[5:3]), {5'h00, config_out.numerator});
         chk("den", lit(e[2:0]), {5'h00, config_out.denominator});
         rd(8'h18, e);
      end
      $display("test random_rw done");
      wr(8'h17, 8'hC0);
      clk_en_in = 1'b0;
      wr(8'h17, 8'h00);
      clk_en_in = 1'b1;
      wr(8'h19, 8'h00);
      rd(8'h17, 8'hC0);
      rd(8'h19, 8'h00);
      $display("test refusal done");
      report_and_stop();
   end
endmodule : test_rate_converter_config
